//--- core/cpor_pkg.sv
// package for the charger protection option registers
// assumes a 20 MHz ref_clk and an i2c master on scl/sda
package cpor_pkg;
    // timing
    localparam int CLK_HZ = 20_000_000;
    localparam int BLANK_NS = 100_000;
    localparam int BLANK_CYC = (BLANK_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam logic [11:0] BLANK_LAST = 12'(BLANK_CYC - 1);

    // bus identity; value is arbitrary
    localparam logic [6:0] DEV_ADDR = 7'h2A;

    // register byte addresses
    localparam logic [7:0] ADDR_OPT2_LO = 8'h32;
    localparam logic [7:0] ADDR_OPT2_HI = 8'h33;
    localparam logic [7:0] ADDR_OPT3_LO = 8'h34;
    localparam logic [7:0] ADDR_OPT3_HI = 8'h35;
    localparam int OPT_BYTES = 4;
    localparam logic [1:0] IDX_OPT2_LO = 2'h0;
    localparam logic [1:0] IDX_OPT2_HI = 2'h1;
    localparam logic [1:0] IDX_OPT3_LO = 2'h2;
    localparam logic [1:0] IDX_OPT3_HI = 2'h3;

    // reset values
    localparam logic [15:0] OPT2_RST = 16'h02B7;
    localparam logic [15:0] OPT3_RST = 16'h0030;
    localparam logic [7:0] OPT_RST [OPT_BYTES] = '{OPT2_RST[7:0], OPT2_RST[15:8],
                                                   OPT3_RST[7:0], OPT3_RST[15:8]};

    // protection_option_low field positions
    localparam int EXT_LIMIT_BIT = 7;
    localparam int MON_POL_BIT = 6;
    localparam int LOWSIDE_OC_BIT = 5;
    localparam int INPUT_OC_BIT = 4;
    localparam int IN_OC_EN_BIT = 3;
    localparam int IN_OC_LVL_BIT = 2;
    localparam int DIS_OC_EN_BIT = 1;
    localparam int DIS_OC_LVL_BIT = 0;

    // threshold codes (mV or percent)
    localparam logic [8:0] LOWSIDE_OC_HI_MV = 9'h0D2;
    localparam logic [8:0] LOWSIDE_OC_LO_MV = 9'h096;
    localparam logic [8:0] INPUT_OC_HI_MV = 9'h118;
    localparam logic [8:0] INPUT_OC_LO_MV = 9'h096;
    localparam logic [8:0] PCT_LOW = 9'h085;
    localparam logic [8:0] PCT_HIGH = 9'h0C8;

    typedef enum logic [8:0] {
        ST_IDLE = 9'h001,
        ST_ADDR = 9'h002,
        ST_AACK = 9'h004,
        ST_PTR = 9'h008,
        ST_PACK = 9'h010,
        ST_WDAT = 9'h020,
        ST_WACK = 9'h040,
        ST_RDAT = 9'h080,
        ST_RACK = 9'h100
    } cpor_state_t;
endpackage

//--- core/cpor_bus_if.sv
// byte access path between the i2c engine and the register bank
// assumes both ends run on ref_clk
`timescale 1ns/100ps
interface cpor_bus_if;
    logic wrStb;
    logic [7:0] addr;
    logic [7:0] wrData;
    logic [7:0] rdData;
    modport engine (output wrStb, output addr, output wrData, input rdData);
    modport regs (input wrStb, input addr, input wrData, output rdData);
endinterface

//--- core/cpor_i2c_engine.sv
// i2c target engine: address match, register pointer, byte writes and reads
// assumes scl/sda already synchronous to ref_clk; sda is open drain
`timescale 1ns/100ps
module cpor_i2c_engine (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // pins
    input wire logic scl,
    input wire logic sdaIn,
    output logic sdaOe,
    // register side
    cpor_bus_if.engine bus
);
    cpor_pkg::cpor_state_t state_ff;
    logic sclPrev_ff, sdaPrev_ff, byteDone_ff, isRead_ff, nack_ff, oe_ff, wrStb_ff;
    logic [2:0] bitCnt_ff;
    logic [7:0] rx_ff, tx_ff, ptr_ff, wrData_ff;
    logic sclRise, sclFall, startCond, stopCond;

    assign sclRise = scl & ~sclPrev_ff;
    assign sclFall = ~scl & sclPrev_ff;
    assign startCond = scl & sclPrev_ff & sdaPrev_ff & ~sdaIn;
    assign stopCond = scl & sclPrev_ff & ~sdaPrev_ff & sdaIn;
    assign sdaOe = oe_ff;
    assign bus.wrStb = wrStb_ff;
    assign bus.addr = ptr_ff;
    assign bus.wrData = wrData_ff;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sclPrev_ff <= 1'b1;
            sdaPrev_ff <= 1'b1;
        end else begin
            sclPrev_ff <= scl;
            sdaPrev_ff <= sdaIn;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= cpor_pkg::ST_IDLE;
            bitCnt_ff <= 3'h0;
            byteDone_ff <= 1'b0;
            rx_ff <= 8'h00;
            tx_ff <= 8'h00;
            ptr_ff <= 8'h00;
            wrData_ff <= 8'h00;
            isRead_ff <= 1'b0;
            nack_ff <= 1'b0;
            oe_ff <= 1'b0;
            wrStb_ff <= 1'b0;
        end else begin
            wrStb_ff <= 1'b0;
            if (startCond) begin
                // repeated start keeps the pointer for a combined write/read
                state_ff <= cpor_pkg::ST_ADDR;
                bitCnt_ff <= 3'h0;
                byteDone_ff <= 1'b0;
                oe_ff <= 1'b0;
            end else if (stopCond) begin
                state_ff <= cpor_pkg::ST_IDLE;
                oe_ff <= 1'b0;
            end else if (sclRise) begin
                if (state_ff inside {cpor_pkg::ST_ADDR, cpor_pkg::ST_PTR, cpor_pkg::ST_WDAT,
                                     cpor_pkg::ST_RDAT}) begin
                    rx_ff <= {rx_ff[6:0], sdaIn};
                    bitCnt_ff <= bitCnt_ff + 3'h1;
                    byteDone_ff <= (bitCnt_ff == 3'h7);
                end else if (state_ff == cpor_pkg::ST_RACK) begin
                    nack_ff <= sdaIn;
                end
            end else if (sclFall) begin
                case (state_ff)
                    cpor_pkg::ST_ADDR: begin
                        if (byteDone_ff) begin
                            byteDone_ff <= 1'b0;
                            if (rx_ff[7:1] == cpor_pkg::DEV_ADDR) begin
                                state_ff <= cpor_pkg::ST_AACK;
                                oe_ff <= 1'b1;
                                isRead_ff <= rx_ff[0];
                            end else begin
                                state_ff <= cpor_pkg::ST_IDLE;
                            end
                        end
                    end
                    cpor_pkg::ST_AACK: begin
                        bitCnt_ff <= 3'h0;
                        if (isRead_ff) begin
                            state_ff <= cpor_pkg::ST_RDAT;
                            tx_ff <= bus.rdData;
                            oe_ff <= ~bus.rdData[7];
                        end else begin
                            state_ff <= cpor_pkg::ST_PTR;
                            oe_ff <= 1'b0;
                        end
                    end
                    cpor_pkg::ST_PTR: begin
                        if (byteDone_ff) begin
                            byteDone_ff <= 1'b0;
                            ptr_ff <= rx_ff;
                            oe_ff <= 1'b1;
                            state_ff <= cpor_pkg::ST_PACK;
                        end
                    end
                    cpor_pkg::ST_PACK: begin
                        oe_ff <= 1'b0;
                        bitCnt_ff <= 3'h0;
                        state_ff <= cpor_pkg::ST_WDAT;
                    end
                    cpor_pkg::ST_WDAT: begin
                        if (byteDone_ff) begin
                            byteDone_ff <= 1'b0;
                            wrStb_ff <= 1'b1;
                            wrData_ff <= rx_ff;
                            oe_ff <= 1'b1;
                            state_ff <= cpor_pkg::ST_WACK;
                        end
                    end
                    cpor_pkg::ST_WACK: begin
                        oe_ff <= 1'b0;
                        ptr_ff <= ptr_ff + 8'h01;
                        bitCnt_ff <= 3'h0;
                        state_ff <= cpor_pkg::ST_WDAT;
                    end
                    cpor_pkg::ST_RDAT: begin
                        if (byteDone_ff) begin
                            byteDone_ff <= 1'b0;
                            oe_ff <= 1'b0;
                            ptr_ff <= ptr_ff + 8'h01;
                            state_ff <= cpor_pkg::ST_RACK;
                        end else begin
                            tx_ff <= {tx_ff[6:0], 1'b0};
                            oe_ff <= ~tx_ff[6];
                        end
                    end
                    cpor_pkg::ST_RACK: begin
                        bitCnt_ff <= 3'h0;
                        if (nack_ff) begin
                            state_ff <= cpor_pkg::ST_IDLE;
                        end else begin
                            tx_ff <= bus.rdData;
                            oe_ff <= ~bus.rdData[7];
                            state_ff <= cpor_pkg::ST_RDAT;
                        end
                    end
                    default: begin
                        oe_ff <= 1'b0;
                    end
                endcase
            end
        end
    end
endmodule // cpor_i2c_engine

//--- core/cpor_option_regs.sv
// option register bank with input and discharge overcurrent protection
// assumes synchronous scl/sda, comparator inputs synchronous to ref_clk
`timescale 1ns/100ps
module cpor_option_regs (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // i2c pins
    input wire logic scl,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    // current inputs
    input wire logic [7:0] regInputLimit,
    input wire logic [7:0] limitPinCurrent,
    input wire logic [7:0] chargeCurrent,
    input wire logic [7:0] dischargeCurrent,
    // comparators
    input wire logic inputOvercurrent,
    input wire logic dischargeOvercurrent,
    // settings and status
    output logic [7:0] effInputLimit,
    output logic [7:0] batteryCurrentMonitor,
    output logic [8:0] lowsideOcThreshold,
    output logic [8:0] inputOcThreshold,
    output logic [8:0] inputOvercurrentLevel,
    output logic [8:0] dischargeOvercurrentLevel,
    output logic [15:0] modeOptionWord,
    output logic converterDisable
);
    cpor_bus_if bus ();
    logic [7:0] optByte_ff [cpor_pkg::OPT_BYTES];
    logic [7:0] effLimit_ff, monitor_ff, optLow;
    logic [8:0] lowsideTh_ff, inputTh_ff, inLevel_ff, disLevel_ff;
    logic [11:0] blankCnt_ff;
    logic inputTrip_ff, nxt_inputTrip, convDisable_ff, inEnOc, disEnOc;
    logic [2:0] wrSel, rdSel;

    // {hit, index}; unmapped addresses read zero and drop writes
    function automatic logic [2:0] decodeAddr(input logic [7:0] a);
        if (a == cpor_pkg::ADDR_OPT2_LO) begin
            return {1'b1, cpor_pkg::IDX_OPT2_LO};
        end else if (a == cpor_pkg::ADDR_OPT2_HI) begin
            return {1'b1, cpor_pkg::IDX_OPT2_HI};
        end else if (a == cpor_pkg::ADDR_OPT3_LO) begin
            return {1'b1, cpor_pkg::IDX_OPT3_LO};
        end else if (a == cpor_pkg::ADDR_OPT3_HI) begin
            return {1'b1, cpor_pkg::IDX_OPT3_HI};
        end else begin
            return 3'h0;
        end
    endfunction

    cpor_i2c_engine u_engine (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .scl(scl),
        .sdaIn(sdaIn),
        .sdaOe(sdaOe),
        .bus(bus.engine)
    );

    assign sdaOut = 1'b0;
    assign wrSel = decodeAddr(bus.addr);
    assign rdSel = decodeAddr(bus.addr);
    assign bus.rdData = rdSel[2] ? optByte_ff[rdSel[1:0]] : 8'h00;

    for (genvar g = 0; g < cpor_pkg::OPT_BYTES; g++) begin : g_opt
        always_ff @(posedge ref_clk or negedge reset_n) begin
            if (!reset_n) begin
                optByte_ff[g] <= cpor_pkg::OPT_RST[g];
            end else if (bus.wrStb && wrSel[2] && wrSel[1:0] == 2'(g)) begin
                optByte_ff[g] <= bus.wrData;
            end
        end
    end

    assign optLow = optByte_ff[cpor_pkg::IDX_OPT2_LO];
    assign modeOptionWord = {optByte_ff[cpor_pkg::IDX_OPT3_HI], optByte_ff[cpor_pkg::IDX_OPT3_LO]};

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            effLimit_ff <= 8'h00;
            monitor_ff <= 8'h00;
        end else begin
            if (optLow[cpor_pkg::EXT_LIMIT_BIT] && limitPinCurrent < regInputLimit) begin
                effLimit_ff <= limitPinCurrent;
            end else begin
                effLimit_ff <= regInputLimit;
            end
            monitor_ff <= optLow[cpor_pkg::MON_POL_BIT] ? chargeCurrent : dischargeCurrent;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            lowsideTh_ff <= cpor_pkg::LOWSIDE_OC_LO_MV;
            inputTh_ff <= cpor_pkg::INPUT_OC_LO_MV;
            inLevel_ff <= cpor_pkg::PCT_HIGH;
            disLevel_ff <= cpor_pkg::PCT_HIGH;
        end else begin
            lowsideTh_ff <= optLow[cpor_pkg::LOWSIDE_OC_BIT] ?
                cpor_pkg::LOWSIDE_OC_LO_MV : cpor_pkg::LOWSIDE_OC_HI_MV;
            inputTh_ff <= optLow[cpor_pkg::INPUT_OC_BIT] ?
                cpor_pkg::INPUT_OC_LO_MV : cpor_pkg::INPUT_OC_HI_MV;
            inLevel_ff <= optLow[cpor_pkg::IN_OC_LVL_BIT] ?
                cpor_pkg::PCT_HIGH : cpor_pkg::PCT_LOW;
            disLevel_ff <= optLow[cpor_pkg::DIS_OC_LVL_BIT] ?
                cpor_pkg::PCT_HIGH : cpor_pkg::PCT_LOW;
        end
    end

    // blanking restarts whenever the condition drops, so glitches never add up
    assign inEnOc = optLow[cpor_pkg::IN_OC_EN_BIT] & inputOvercurrent;
    assign disEnOc = optLow[cpor_pkg::DIS_OC_EN_BIT] & dischargeOvercurrent;
    assign nxt_inputTrip = inEnOc & (inputTrip_ff | blankCnt_ff == cpor_pkg::BLANK_LAST);

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            blankCnt_ff <= 12'h000;
            inputTrip_ff <= 1'b0;
            convDisable_ff <= 1'b0;
        end else begin
            if (inEnOc && blankCnt_ff != cpor_pkg::BLANK_LAST) begin
                blankCnt_ff <= blankCnt_ff + 12'h001;
            end else if (!inEnOc) begin
                blankCnt_ff <= 12'h000;
            end
            inputTrip_ff <= nxt_inputTrip;
            convDisable_ff <= nxt_inputTrip | disEnOc;
        end
    end

    assign effInputLimit = effLimit_ff;
    assign batteryCurrentMonitor = monitor_ff;
    assign lowsideOcThreshold = lowsideTh_ff;
    assign inputOcThreshold = inputTh_ff;
    assign inputOvercurrentLevel = inLevel_ff;
    assign dischargeOvercurrentLevel = disLevel_ff;
    assign converterDisable = convDisable_ff;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    a_limit_register: assert property (
        !optLow[cpor_pkg::EXT_LIMIT_BIT] |=> effInputLimit == $past(regInputLimit))
        else $error("register limit not used");
    a_limit_lower: assert property (
        optLow[cpor_pkg::EXT_LIMIT_BIT] && limitPinCurrent < regInputLimit
        |=> effInputLimit == $past(limitPinCurrent))
        else $error("lower pin limit not used");
    a_monitor_polarity: assert property (
        !optLow[cpor_pkg::MON_POL_BIT] |=> batteryCurrentMonitor == $past(dischargeCurrent))
        else $error("monitor does not show discharge");
    a_lowside_threshold: assert property (
        !optLow[cpor_pkg::LOWSIDE_OC_BIT] |=> lowsideOcThreshold == 9'h0D2)
        else $error("low-side threshold not 210 mV");
    a_input_threshold: assert property (
        !optLow[cpor_pkg::INPUT_OC_BIT] |=> inputOcThreshold == 9'h118)
        else $error("input threshold not 280 mV");
    a_blank_length: assert property (
        $rose(converterDisable) && !$past(disEnOc) |-> $past(blankCnt_ff) == 12'h7CF)
        else $error("input trip before 100 us blanking");
    a_blank_short: assert property (
        !inEnOc ##1 inEnOc [*8] |-> !inputTrip_ff)
        else $error("input trip inside blanking");
    a_input_level: assert property (
        !optLow[cpor_pkg::IN_OC_LVL_BIT] |=> inputOvercurrentLevel == 9'h085)
        else $error("input level not 133 percent");
    a_discharge_trip: assert property (
        disEnOc |=> converterDisable)
        else $error("discharge overcurrent did not disable");
    a_discharge_off: assert property (
        !optLow[cpor_pkg::DIS_OC_EN_BIT] && !inEnOc |=> !converterDisable)
        else $error("disabled protection tripped");
    a_discharge_level: assert property (
        !optLow[cpor_pkg::DIS_OC_LVL_BIT] |=> dischargeOvercurrentLevel == 9'h085)
        else $error("discharge level not 133 percent");
    a_mode_reset: assert property (
        $past(!reset_n) |-> modeOptionWord == 16'h0030)
        else $error("mode word reset wrong");
    a_prot_reset: assert property (
        $past(!reset_n) |-> {optByte_ff[1], optByte_ff[0]} == 16'h02B7)
        else $error("protection pair reset wrong");
    a_write_store: assert property (
        bus.wrStb && bus.addr == 8'h32 |=> optLow == $past(bus.wrData) ##1 1'b1)
        else $error("write not stored");
    a_limit_upper: assert property (
        optLow[cpor_pkg::EXT_LIMIT_BIT] && !(limitPinCurrent < regInputLimit)
        |=> effInputLimit == $past(regInputLimit))
        else $error("register limit not kept when lower");
    a_monitor_charge: assert property (
        optLow[cpor_pkg::MON_POL_BIT] |=> batteryCurrentMonitor == $past(chargeCurrent))
        else $error("monitor does not show charge");
    a_lowside_default: assert property (
        optLow[cpor_pkg::LOWSIDE_OC_BIT] |=> lowsideOcThreshold == 9'h096)
        else $error("low-side threshold not 150 mV");
    a_input_default: assert property (
        optLow[cpor_pkg::INPUT_OC_BIT] |=> inputOcThreshold == 9'h096)
        else $error("input threshold not 150 mV");
    a_trip_hold: assert property (
        inputTrip_ff && inEnOc |=> converterDisable)
        else $error("held input overcurrent released the converter");
    a_level_high: assert property (
        optLow[cpor_pkg::IN_OC_LVL_BIT] |=> inputOvercurrentLevel == 9'h0C8)
        else $error("input level not 200 percent");
    a_discharge_high: assert property (
        optLow[cpor_pkg::DIS_OC_LVL_BIT] |=> dischargeOvercurrentLevel == 9'h0C8)
        else $error("discharge level not 200 percent");
    a_mode_store: assert property (
        bus.wrStb && bus.addr == 8'h35 |=> modeOptionWord[15:8] == $past(bus.wrData))
        else $error("mode word high byte not stored");

    c_input_trip: cover property (inEnOc ##1 $rose(inputTrip_ff));
    c_discharge_trip: cover property ($rose(disEnOc));
    c_write_opt3: cover property (bus.wrStb && bus.addr == 8'h34);
    c_limit_pin: cover property (
        optLow[cpor_pkg::EXT_LIMIT_BIT] && limitPinCurrent < regInputLimit);
    c_charge_monitor: cover property (optLow[cpor_pkg::MON_POL_BIT]);
endmodule // cpor_option_regs

//--- tb/cpor_host_model.sv
// host controller model acting as i2c master on scl/sda
// assumes sda has a pull-up and the bench resolves the wire from both enables
`timescale 1ns/100ps
module cpor_host_model (
    // clock
    input wire logic ref_clk,
    // bus wires
    input wire logic sdaWire,
    output logic scl,
    output logic sdaOe
);
    // each scl phase is at least four ref_clk cycles, above the two-cycle minimum
    localparam int HALF = 4;

    initial begin
        scl = 1'b1;
        sdaOe = 1'b0;
    end

    task automatic waitCyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    // also serves as repeated start from scl low
    task automatic busStart();
        sdaOe = 1'b0;
        waitCyc(HALF);
        scl = 1'b1;
        waitCyc(HALF);
        sdaOe = 1'b1;
        waitCyc(HALF);
        scl = 1'b0;
        waitCyc(HALF);
    endtask

    task automatic busStop();
        sdaOe = 1'b1;
        waitCyc(HALF);
        scl = 1'b1;
        waitCyc(HALF);
        sdaOe = 1'b0;
        waitCyc(HALF);
    endtask

    // sda only moves while scl is low; sampled at the end of the high phase
    task automatic bitOut(input logic b, output logic seen);
        sdaOe = ~b;
        waitCyc(HALF);
        scl = 1'b1;
        waitCyc(HALF);
        seen = sdaWire;
        scl = 1'b0;
        waitCyc(1);
    endtask

    task automatic sendByte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bitOut(d[i], s);
        end
        bitOut(1'b1, s);
        ack = ~s;
    endtask

    // master nack on the last byte ends the read
    task automatic recvByte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bitOut(1'b1, d[i]);
        end
        bitOut(last, s);
    endtask
endmodule // cpor_host_model

//--- tb/cpor_option_regs_tb.sv
// self-checking bench for the option register bank
// assumes the host model above drives the i2c side; sda pulled up
`timescale 1ns/100ps
module cpor_option_regs_tb;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic scl, hostOe, sdaOut, sdaOe, sdaWire, ack, converterDisable;
    logic [7:0] regInputLimit = 8'h00, limitPinCurrent = 8'h00;
    logic [7:0] chargeCurrent = 8'h00, dischargeCurrent = 8'h00, v;
    logic inputOvercurrent = 1'b0, dischargeOvercurrent = 1'b0;
    logic [7:0] effInputLimit, batteryCurrentMonitor;
    logic [8:0] lowsideOcThreshold, inputOcThreshold;
    logic [8:0] inputOvercurrentLevel, dischargeOvercurrentLevel;
    logic [15:0] modeOptionWord, rd;
    logic [31:0] rnd = 32'h0001_3116;
    int n_errors = 0;
    int checks = 0;

    always #25 ref_clk = ~ref_clk;
    assign sdaWire = (sdaOe ? sdaOut : 1'b1) & ~hostOe;

    cpor_option_regs DUT (.ref_clk(ref_clk), .reset_n(reset_n), .scl(scl), .sdaIn(sdaWire),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .regInputLimit(regInputLimit),
        .limitPinCurrent(limitPinCurrent), .chargeCurrent(chargeCurrent),
        .dischargeCurrent(dischargeCurrent), .inputOvercurrent(inputOvercurrent),
        .dischargeOvercurrent(dischargeOvercurrent), .effInputLimit(effInputLimit),
        .batteryCurrentMonitor(batteryCurrentMonitor), .lowsideOcThreshold(lowsideOcThreshold),
        .inputOcThreshold(inputOcThreshold), .inputOvercurrentLevel(inputOvercurrentLevel),
        .dischargeOvercurrentLevel(dischargeOvercurrentLevel), .modeOptionWord(modeOptionWord),
        .converterDisable(converterDisable));
    cpor_host_model host (.ref_clk(ref_clk), .sdaWire(sdaWire), .scl(scl), .sdaOe(hostOe));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks=%0d n_errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    function automatic void nextRnd();
        rnd = rnd[0] ? ((rnd >> 1) ^ 32'h8020_0003) : (rnd >> 1);
    endfunction

    function automatic logic [15:0] pick(input logic b, input logic [8:0] one,
        input logic [8:0] zero);
        return 16'(b ? one : zero);
    endfunction

    function automatic logic [15:0] expLimit(input logic sel, input logic [7:0] r,
        input logic [7:0] p);
        return 16'((sel && p < r) ? p : r);
    endfunction

    task automatic addrPhase(input logic rdBit);
        host.busStart();
        host.sendByte({cpor_pkg::DEV_ADDR, rdBit}, ack);
        check(16'(ack), 16'h0001);
    endtask

    task automatic wrBytes(input logic [7:0] ptr, input logic [15:0] d, input int n);
        addrPhase(1'b0);
        host.sendByte(ptr, ack);
        for (int i = 0; i < n; i++) begin
            host.sendByte(d[8*i +: 8], ack);
            check(16'(ack), 16'h0001);
        end
        host.busStop();
    endtask

    task automatic rdBytes(input logic [7:0] ptr, input int n, output logic [15:0] d);
        logic [7:0] b;
        d = 16'h0000;
        addrPhase(1'b0);
        host.sendByte(ptr, ack);
        addrPhase(1'b1);
        for (int i = 0; i < n; i++) begin
            host.recvByte(i == n - 1, b);
            d[8*i +: 8] = b;
        end
        host.busStop();
    endtask

    task automatic checkFields(input logic [7:0] f);
        check(16'(lowsideOcThreshold), pick(f[5], cpor_pkg::LOWSIDE_OC_LO_MV,
            cpor_pkg::LOWSIDE_OC_HI_MV));
        check(16'(inputOcThreshold), pick(f[4], cpor_pkg::INPUT_OC_LO_MV,
            cpor_pkg::INPUT_OC_HI_MV));
        check(16'(inputOvercurrentLevel), pick(f[2], cpor_pkg::PCT_HIGH, cpor_pkg::PCT_LOW));
        check(16'(dischargeOvercurrentLevel), pick(f[0], cpor_pkg::PCT_HIGH,
            cpor_pkg::PCT_LOW));
        nextRnd();
        {dischargeCurrent, chargeCurrent, limitPinCurrent, regInputLimit} = rnd;
        repeat (2) @(negedge ref_clk);
        check(16'(effInputLimit), expLimit(f[7], regInputLimit, limitPinCurrent));
        check(16'(batteryCurrentMonitor), 16'(f[6] ? chargeCurrent : dischargeCurrent));
    endtask

    // hang guard
    initial begin
        repeat (100000) @(posedge ref_clk);
        n_errors++;
        tally_and_finish();
    end

    initial begin
        repeat (8) @(negedge ref_clk);
        reset_n = 1'b1;
        repeat (2) @(negedge ref_clk);
        checkFields(cpor_pkg::OPT2_RST[7:0]);
        check(modeOptionWord, 16'h0030);
        rdBytes(cpor_pkg::ADDR_OPT2_LO, 2, rd);
        check(rd, 16'h02B7);
        rdBytes(cpor_pkg::ADDR_OPT3_LO, 2, rd);
        check(rd, 16'h0030);
        for (int i = 0; i < 8; i++) begin
            nextRnd();
            v = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : rnd[7:0];
            wrBytes(cpor_pkg::ADDR_OPT2_LO, {8'h00, v}, 1);
            rdBytes(cpor_pkg::ADDR_OPT2_LO, 1, rd);
            check(rd, {8'h00, v});
            checkFields(v);
            check(16'(converterDisable), 16'h0000);
        end
        nextRnd();
        wrBytes(cpor_pkg::ADDR_OPT3_LO, rnd[15:0], 2);
        check(modeOptionWord, rnd[15:0]);
        rdBytes(cpor_pkg::ADDR_OPT3_LO, 2, rd);
        check(rd, rnd[15:0]);
        // unmapped pointer: write dropped, read gives zero
        wrBytes(8'h40, 16'h00A5, 1);
        rdBytes(8'h40, 1, rd);
        check(rd, 16'h0000);
        // a short trip must restart the blanking count
        wrBytes(cpor_pkg::ADDR_OPT2_LO, 16'h000C, 1);
        inputOvercurrent = 1'b1;
        repeat (1000) @(negedge ref_clk);
        inputOvercurrent = 1'b0;
        repeat (2) @(negedge ref_clk);
        check(16'(converterDisable), 16'h0000);
        inputOvercurrent = 1'b1;
        repeat (1995) @(negedge ref_clk);
        check(16'(converterDisable), 16'h0000);
        repeat (10) @(negedge ref_clk);
        check(16'(converterDisable), 16'h0001);
        wrBytes(cpor_pkg::ADDR_OPT2_LO, 16'h0004, 1);
        check(16'(converterDisable), 16'h0000);
        inputOvercurrent = 1'b0;
        wrBytes(cpor_pkg::ADDR_OPT2_LO, 16'h0002, 1);
        dischargeOvercurrent = 1'b1;
        @(negedge ref_clk);
        check(16'(converterDisable), 16'h0001);
        dischargeOvercurrent = 1'b0;
        @(negedge ref_clk);
        check(16'(converterDisable), 16'h0000);
        wrBytes(cpor_pkg::ADDR_OPT2_LO, 16'h0000, 1);
        dischargeOvercurrent = 1'b1;
        repeat (3) @(negedge ref_clk);
        check(16'(converterDisable), 16'h0000);
        dischargeOvercurrent = 1'b0;
        // mid-run reset must bring back defaults over written values
        @(negedge ref_clk);
        reset_n = 1'b0;
        repeat (2) @(negedge ref_clk);
        reset_n = 1'b1;
        repeat (2) @(negedge ref_clk);
        check(modeOptionWord, 16'h0030);
        checkFields(cpor_pkg::OPT2_RST[7:0]);
        rdBytes(cpor_pkg::ADDR_OPT2_LO, 2, rd);
        check(rd, 16'h02B7);
        tally_and_finish();
    end
endmodule // cpor_option_regs_tb
